/* File: rsc_pkg.sv */
/*
  Constants of the resizer source control block: register offsets, field
  positions, reset values, the run state encoding and the line limit.
  Assumes a byte-addressed Avalon-MM slave with 32-bit data.
*/
package rsc_pkg;

  // ==========================================================================
  // Bus geometry
  // ==========================================================================
  localparam int          RSC_ADDR_W = 9;
  localparam int          RSC_DATA_W = 32;
  localparam int          RSC_BE_W   = 4;

  // ==========================================================================
  // Register offsets
  // ==========================================================================
  localparam logic [8:0]  RSC_OFS_START_CTRL   = 9'h004;
  localparam logic [8:0]  RSC_OFS_RUN_MODE     = 9'h008;
  localparam logic [8:0]  RSC_OFS_FMT_SELECT   = 9'h00c;
  localparam logic [8:0]  RSC_OFS_C_LINE_OFS   = 9'h16c;
  localparam logic [8:0]  RSC_OFS_C_START_PTR  = 9'h170;
  localparam logic [8:0]  RSC_OFS_C_END_PTR    = 9'h174;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int          RSC_BIT_START        = 0;
  localparam int          RSC_BIT_SINGLE_RUN   = 0;
  localparam int          RSC_BIT_WR_QUAL      = 1;
  localparam int          RSC_BIT_SRC_SEL      = 0;
  localparam int          RSC_BIT_PASS_THRU    = 1;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [31:0] RSC_RST_REG          = 32'h0000_0000;
  localparam logic [31:0] RSC_ZERO_WORD        = 32'h0000_0000;

  // ==========================================================================
  // Pass-through line limit
  // ==========================================================================
  localparam int          RSC_MAX_RAW_LINE     = 8190;
  localparam int          RSC_PIX_CNT_W        = 13;

  // ==========================================================================
  // Run states
  // ==========================================================================
  typedef enum logic [1:0] {
    RSC_IDLE     = 2'b00,
    RSC_WAIT_VS  = 2'b01,
    RSC_RUN      = 2'b10
  } rsc_run_t;

endpackage : rsc_pkg

/* File: rsc_top.sv */
/*
  Resizer source control: start flag, run mode, write qualifier, source and
  pass-through selection, channel B chroma memory registers, and the pixel
  gate that follows them.
  Assumes all inputs synchronous to sys_clk_i and an Avalon-MM master that
  holds each request until waitrequest is seen low.
  Assumes the downstream datapath supplies area_end_i and line_start_i, and
  that software applies the fixed pass-through setup of the scaler channels
  before it sets the pass-through bit; this block checks neither that setup
  nor the reserved bits that software must write as zero.
*/
// Local design decision: the Avalon-MM slave port.
// How it works
// - Start waits for next vertical sync rise
// - Single run clears start flag at end
// - Mode bit 0: free run or single
// - Mode bit 1 enables upstream write qualifier
// - Pass-through skips processing, lines up to 8190
// - Chroma registers at 16Ch, 170h, 174h
// - Format bit 0 selects pipe or interface
`timescale 1ns/100ps

module rsc_top
  import rsc_pkg::*;
#(
  parameter int PIX_W = 16
) (
  input  wire logic                  sys_clk_i,          // System clock, 125 MHz
  input  wire logic                  resetn_i,           // Async reset, active low
  input  wire logic [RSC_ADDR_W-1:0] avs_address_i,      // Byte address
  input  wire logic                  avs_read_i,         // Read request
  input  wire logic                  avs_write_i,        // Write request
  input  wire logic [RSC_DATA_W-1:0] avs_writedata_i,    // Write data
  input  wire logic [RSC_BE_W-1:0]   avs_byteenable_i,   // Byte lanes
  output logic      [RSC_DATA_W-1:0] avs_readdata_o,     // Read data
  output logic                       avs_waitrequest_o,  // Slave stall
  input  wire logic                  vertical_sync_i,    // Vertical sync pulse
  input  wire logic                  line_start_i,       // First pixel of a line
  input  wire logic                  area_end_i,         // End of processing area
  input  wire logic [PIX_W-1:0]      pipe_data_i,        // Image pipe pixel
  input  wire logic                  pipe_valid_i,       // Image pipe pixel valid
  input  wire logic [PIX_W-1:0]      pif_data_i,         // Pipe interface pixel
  input  wire logic                  pif_valid_i,        // Pipe interface pixel valid
  input  wire logic                  upstream_wen_i,     // Upstream write enable
  output logic      [PIX_W-1:0]      pix_data_o,         // Selected pixel
  output logic                       pix_valid_o,        // Selected pixel valid
  output logic                       pass_thru_o,        // Processing skipped
  output logic                       running_o,          // Processing active
  output logic                       area_done_o         // Area finished, pulse
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic                     waitreq;
    logic [RSC_DATA_W-1:0]    rdata;
    logic                     start_flag;
    logic                     single_run;
    logic                     wr_qual;
    logic                     src_sel;
    logic                     pass_thru;
    logic [RSC_DATA_W-1:0]    c_line_ofs;
    logic [RSC_DATA_W-1:0]    c_start_ptr;
    logic [RSC_DATA_W-1:0]    c_end_ptr;
    logic                     vs_prev;
    rsc_run_t                 run;
    logic                     running;
    logic [RSC_PIX_CNT_W-1:0] pix_cnt;
    logic [PIX_W-1:0]         pix_data;
    logic                     pix_valid;
    logic                     area_done;
  } rsc_state_t;

  localparam logic [RSC_PIX_CNT_W-1:0] PIX_LIMIT = RSC_PIX_CNT_W'(RSC_MAX_RAW_LINE);
  localparam logic [RSC_PIX_CNT_W-1:0] PIX_ONE   = RSC_PIX_CNT_W'(1);
  localparam int                       BYTE_W    = 8;

  // Reset image of the whole state; the bus idles stalled
  localparam rsc_state_t ST_RESET = '{
    waitreq:     1'b1,
    rdata:       RSC_RST_REG,
    start_flag:  1'b0,
    single_run:  1'b0,
    wr_qual:     1'b0,
    src_sel:     1'b0,
    pass_thru:   1'b0,
    c_line_ofs:  RSC_RST_REG,
    c_start_ptr: RSC_RST_REG,
    c_end_ptr:   RSC_RST_REG,
    vs_prev:     1'b0,
    run:         RSC_IDLE,
    running:     1'b0,
    pix_cnt:     '0,
    pix_data:    '0,
    pix_valid:   1'b0,
    area_done:   1'b0
  };

  rsc_state_t st;
  rsc_state_t next_st;

  // ==========================================================================
  // Byte-lane merge of a write into a stored word
  // ==========================================================================
  function automatic logic [RSC_DATA_W-1:0] rsc_merge(
    input logic [RSC_DATA_W-1:0] old_w,
    input logic [RSC_DATA_W-1:0] new_w,
    input logic [RSC_BE_W-1:0]   be
  );
    logic [RSC_DATA_W-1:0] res;
    res = old_w;
    for (int i = 0; i < RSC_BE_W; i++) begin
      if (be[i]) begin
        res[i*BYTE_W +: BYTE_W] = new_w[i*BYTE_W +: BYTE_W];
      end
    end
    return res;
  endfunction : rsc_merge

  // ==========================================================================
  // Next state
  // ==========================================================================
  logic                  bus_req;
  logic                  wr_now;
  logic                  vs_rise;
  logic                  lane0;
  logic [RSC_DATA_W-1:0] rd_mux;
  logic                  sel_valid;
  logic [PIX_W-1:0]      sel_data;
  logic                  qual_ok;
  logic                  sw_start_wr;
  logic                  line_room;
  logic                  pix_take;

  always_comb begin
    next_st     = st;

    // ========================================================================
    // Decoded strobes
    // ========================================================================
    bus_req     = avs_read_i | avs_write_i;
    wr_now      = avs_write_i & ~st.waitreq;
    lane0       = avs_byteenable_i[0];
    // vs_prev resets low like an idle pin: no false rise after reset
    vs_rise     = vertical_sync_i & ~st.vs_prev;
    sw_start_wr = wr_now & lane0 & (avs_address_i == RSC_OFS_START_CTRL);

    // ========================================================================
    // Register read
    // ========================================================================
    // Unmapped addresses and reserved bits read zero
    rd_mux = RSC_ZERO_WORD;
    case (avs_address_i)
      RSC_OFS_START_CTRL:  rd_mux[RSC_BIT_START]      = st.start_flag;
      RSC_OFS_RUN_MODE: begin
        rd_mux[RSC_BIT_SINGLE_RUN] = st.single_run;
        rd_mux[RSC_BIT_WR_QUAL]    = st.wr_qual;
      end
      RSC_OFS_FMT_SELECT: begin
        rd_mux[RSC_BIT_SRC_SEL]    = st.src_sel;
        rd_mux[RSC_BIT_PASS_THRU]  = st.pass_thru;
      end
      RSC_OFS_C_LINE_OFS:  rd_mux = st.c_line_ofs;
      RSC_OFS_C_START_PTR: rd_mux = st.c_start_ptr;
      RSC_OFS_C_END_PTR:   rd_mux = st.c_end_ptr;
      default:             rd_mux = RSC_ZERO_WORD;
    endcase

    // ========================================================================
    // Bus handshake
    // ========================================================================
    // One stall cycle, then the answer; read data is captured in the stall
    // so that it stands at the edge where waitrequest is seen low
    if (bus_req && st.waitreq) begin
      next_st.waitreq = 1'b0;
      next_st.rdata   = rd_mux;
    end else begin
      next_st.waitreq = 1'b1;
    end

    // ========================================================================
    // Register write
    // ========================================================================
    // Control bits live in lane 0 only; the chroma words merge per lane
    if (wr_now) begin
      case (avs_address_i)
        RSC_OFS_RUN_MODE: begin
          if (lane0) begin
            next_st.single_run = avs_writedata_i[RSC_BIT_SINGLE_RUN];
            next_st.wr_qual    = avs_writedata_i[RSC_BIT_WR_QUAL];
          end
        end
        RSC_OFS_FMT_SELECT: begin
          if (lane0) begin
            next_st.src_sel    = avs_writedata_i[RSC_BIT_SRC_SEL];
            next_st.pass_thru  = avs_writedata_i[RSC_BIT_PASS_THRU];
          end
        end
        RSC_OFS_C_LINE_OFS:
          next_st.c_line_ofs  = rsc_merge(st.c_line_ofs, avs_writedata_i, avs_byteenable_i);
        RSC_OFS_C_START_PTR:
          next_st.c_start_ptr = rsc_merge(st.c_start_ptr, avs_writedata_i, avs_byteenable_i);
        RSC_OFS_C_END_PTR:
          next_st.c_end_ptr   = rsc_merge(st.c_end_ptr, avs_writedata_i, avs_byteenable_i);
        default: begin
        end
      endcase
    end

    // ========================================================================
    // Run control
    // ========================================================================
    next_st.vs_prev   = vertical_sync_i;
    next_st.area_done = 1'b0;
    case (st.run)
      RSC_IDLE: begin
        if (st.start_flag) begin
          next_st.run = RSC_WAIT_VS;
        end
      end
      RSC_WAIT_VS: begin
        if (!st.start_flag) begin
          next_st.run = RSC_IDLE;
        end else if (vs_rise) begin
          next_st.run = RSC_RUN;
        end
      end
      RSC_RUN: begin
        if (area_end_i) begin
          next_st.area_done = 1'b1;
          if (st.single_run) begin
            next_st.start_flag = 1'b0;
            next_st.run        = RSC_IDLE;
          end else if (!st.start_flag) begin
            next_st.run        = RSC_IDLE;
          end else begin
            next_st.run        = RSC_WAIT_VS;
          end
        end
      end
      default: next_st.run = RSC_IDLE;
    endcase

    // Registered copy of the run state drives running_o
    next_st.running = (next_st.run == RSC_RUN);

    // A software write to the start flag overrides the automatic clear,
    // so a restart written in the last cycle of a run is not lost
    if (sw_start_wr) begin
      next_st.start_flag = avs_writedata_i[RSC_BIT_START];
    end

    // ========================================================================
    // Pixel gate
    // ========================================================================
    // Source select, write qualifier, pass-through line limit
    sel_data  = st.src_sel ? pif_data_i  : pipe_data_i;
    sel_valid = st.src_sel ? pif_valid_i : pipe_valid_i;
    qual_ok   = ~st.wr_qual | upstream_wen_i;
    if (line_start_i) begin
      next_st.pix_cnt = RSC_PIX_CNT_W'(0);
    end
    next_st.pix_valid = 1'b0;
    line_room = ~st.pass_thru | line_start_i | (st.pix_cnt < PIX_LIMIT);
    pix_take  = st.running & sel_valid & qual_ok;
    if (pix_take) begin
      if (line_room) begin
        next_st.pix_valid = 1'b1;
        next_st.pix_data  = sel_data;
        next_st.pix_cnt   = (line_start_i ? RSC_PIX_CNT_W'(0) : st.pix_cnt) + PIX_ONE;
      end
    end
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      // Whole state image in one step, constants only
      st <= ST_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign avs_readdata_o    = st.rdata;
  assign avs_waitrequest_o = st.waitreq;
  assign pix_data_o        = st.pix_data;
  assign pix_valid_o       = st.pix_valid;
  assign pass_thru_o       = st.pass_thru;
  assign running_o         = st.running;
  assign area_done_o       = st.area_done;

endmodule : rsc_top

/* File: rsc_src_model.sv */
/*
  Upstream pixel source: random pixels on the pipe and interface inputs.
  Assumes the bench clock and an active-low reset.
*/
`timescale 1ns/100ps
// ======================
// Source model
// ======================
module rsc_src_model (
  input  wire logic        clk_i,    // Clock
  input  wire logic        rstn_i,   // Reset, active low
  input  wire logic        dense_i,  // Valid every cycle
  output logic      [15:0] pipe_d_o, // Pipe pixel
  output logic             pipe_v_o, // Pipe valid
  output logic      [15:0] pif_d_o,  // Interface pixel
  output logic             pif_v_o,  // Interface valid
  output logic             wen_o     // Write enable
);
  logic [31:0] s;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) s <= 32'h2468ace1;
    else s <= s ^ (s << 13) ^ (s >> 7) ^ 32'h9e37_79b9;
  end
  // Data changes every cycle, also between valid pixels
  assign pipe_d_o = s[15:0];
  assign pif_d_o  = s[31:16];
  assign pipe_v_o = rstn_i & (dense_i | s[3]);
  assign pif_v_o  = rstn_i & (dense_i | s[9]);
  assign wen_o    = s[21];
endmodule : rsc_src_model

/* File: rsc_top_props.sv */
/*
  Checker of rsc_top port behaviour.
  Assumes the top ports only; bound into every rsc_top.
*/
`timescale 1ns/100ps
// ======================
// Checker
// ======================
module rsc_top_props
  import rsc_pkg::*;
#(
  parameter int PIX_W = 16
) (
  input wire logic                  sys_clk_i,         // Clock
  input wire logic                  resetn_i,          // Reset, active low
  input wire logic [RSC_ADDR_W-1:0] avs_address_i,     // Address
  input wire logic                  avs_read_i,        // Read
  input wire logic                  avs_write_i,       // Write
  input wire logic                  avs_waitrequest_o, // Stall
  input wire logic                  vertical_sync_i,   // Sync
  input wire logic                  area_end_i,        // Area end
  input wire logic [PIX_W-1:0]      pipe_data_i,       // Pipe pixel
  input wire logic                  pipe_valid_i,      // Pipe valid
  input wire logic [PIX_W-1:0]      pif_data_i,        // Interface pixel
  input wire logic                  pif_valid_i,       // Interface valid
  input wire logic [PIX_W-1:0]      pix_data_o,        // Output pixel
  input wire logic                  pix_valid_o,       // Output valid
  input wire logic                  pass_thru_o,       // Pass-through
  input wire logic                  running_o,         // Running
  input wire logic                  area_done_o        // Area done
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  logic fmt_wr;
  assign fmt_wr = avs_write_i && !avs_waitrequest_o && (avs_address_i == RSC_OFS_FMT_SELECT);
  AST_VS_START: assert property ($rose(running_o) |-> $past(vertical_sync_i) && !$past(vertical_sync_i, 2))
    else $error("run began without a sync rise");
  AST_DONE_CAUSE: assert property (area_done_o |-> $past(area_end_i) && $past(running_o))
    else $error("area done without area end in run");
  AST_DONE_STOPS: assert property ($past(area_end_i) && $past(running_o) |-> area_done_o && !running_o)
    else $error("area end did not finish the run");
  AST_PIX_IN_RUN: assert property (pix_valid_o |-> $past(running_o))
    else $error("pixel passed outside a run");
  AST_PIX_SRC: assert property (pix_valid_o |-> (pix_data_o == $past(pipe_data_i) && $past(pipe_valid_i))
    || (pix_data_o == $past(pif_data_i) && $past(pif_valid_i)))
    else $error("pixel not from a valid source");
  AST_PASS_HOLD: assert property (!$stable(pass_thru_o) |-> $past(fmt_wr) || $past(fmt_wr, 2))
    else $error("pass-through changed without a write");
  AST_WAIT_ONE: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("bus answer late");
  AST_WAIT_BACK: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low too long");
endmodule : rsc_top_props

bind rsc_top rsc_top_props #(.PIX_W(PIX_W)) u_props (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_waitrequest_o(avs_waitrequest_o), .vertical_sync_i(vertical_sync_i), .area_end_i(area_end_i),
  .pipe_data_i(pipe_data_i), .pipe_valid_i(pipe_valid_i), .pif_data_i(pif_data_i),
  .pif_valid_i(pif_valid_i), .pix_data_o(pix_data_o), .pix_valid_o(pix_valid_o),
  .pass_thru_o(pass_thru_o), .running_o(running_o), .area_done_o(area_done_o));

/* File: rsc_top_bench.sv */
/*
  Bench of rsc_top: bus tasks, run scenarios and a pixel monitor.
  Assumes rsc_src_model as the upstream source.
*/
`timescale 1ns/100ps
// ======================
// Bench
// ======================
module rsc_top_bench;
  import rsc_pkg::*;
  localparam logic [8:0] OFS [7] = '{RSC_OFS_START_CTRL, RSC_OFS_RUN_MODE, RSC_OFS_FMT_SELECT,
    RSC_OFS_C_LINE_OFS, RSC_OFS_C_START_PTR, RSC_OFS_C_END_PTR, 9'h010};
  logic        sys_clk_i = 1'b0, resetn_i = 1'b0;
  logic [8:0]  adr = 9'h000;
  logic        rd = 1'b0, wr = 1'b0, vs = 1'b0, ls = 1'b0, ae = 1'b0, dense = 1'b0, mon = 1'b0;
  logic [31:0] wd = 32'h0, rdat, q, v, pw, seed = 32'hf759e7db;
  logic [3:0]  be = 4'hf;
  logic        wq, pv, pt, run, pipv, fv, wen, qual, src, exp_v, ad;
  logic [15:0] pd, fd, pix, exp_d;
  int          miscompares = 0, checked = 0, cnt = 0, dn = 0;
  initial forever #4 sys_clk_i = ~sys_clk_i;
  rsc_src_model u_src (.clk_i(sys_clk_i), .rstn_i(resetn_i), .dense_i(dense), .pipe_d_o(pd),
    .pipe_v_o(pipv), .pif_d_o(fd), .pif_v_o(fv), .wen_o(wen));
  rsc_top dut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wq), .vertical_sync_i(vs), .line_start_i(ls), .area_end_i(ae),
    .pipe_data_i(pd), .pipe_valid_i(pipv), .pif_data_i(fd), .pif_valid_i(fv), .upstream_wen_i(wen),
    .pix_data_o(pix), .pix_valid_o(pv), .pass_thru_o(pt), .running_o(run), .area_done_o(ad));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic end_of_test;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_of_test
  task automatic bus(input logic w, input logic [8:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk_i);
    adr <= a; wr <= w; rd <= !w; wd <= d;
    n = 0;
    do begin @(posedge sys_clk_i); n++; end while (wq !== 1'b0 && n < 50);
    if (wq !== 1'b0) begin miscompares++; end_of_test(); end
    q = rdat;
    wr <= 1'b0; rd <= 1'b0;
  endtask : bus
  // Expected pixel from last cycle's inputs
  always @(negedge sys_clk_i) begin
    if (mon) chk("pix_valid", {31'h0, pv}, {31'h0, exp_v});
    if (mon && exp_v) chk("pix_data", {16'h0, pix}, {16'h0, exp_d});
    if (pv === 1'b1) cnt++;
    if (ad === 1'b1) dn++;
    exp_v = (src ? fv : pipv) && (!qual || wen);
    exp_d = src ? fd : pd;
  end
  initial begin
    repeat (10) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      bus(1'b0, OFS[i], 32'h0);
      chk("reset_value", q, 32'h0);
    end
    be <= 4'he;
    bus(1'b1, RSC_OFS_START_CTRL, 32'h1);
    be <= 4'hf;
    bus(1'b0, RSC_OFS_START_CTRL, 32'h0);
    chk("lane0_gate", q, 32'h0);
    for (int i = 3; i < 7; i++) begin
      v = rnd();
      bus(1'b1, OFS[i], v);
      bus(1'b0, OFS[i], 32'h0);
      chk("readback", q, (i < 6) ? v : 32'h0);
      pw = rnd();
      be <= 4'h5;
      bus(1'b1, OFS[i], pw);
      be <= 4'hf;
      bus(1'b0, OFS[i], 32'h0);
      chk("lane_merge", q, (i < 6) ? {v[31:24], pw[23:16], v[15:8], pw[7:0]} : 32'h0);
    end
    for (int m = 0; m < 8; m++) begin
      qual = m[1];
      src = m[2];
      bus(1'b1, RSC_OFS_RUN_MODE, {30'h0, m[1:0]});
      bus(1'b1, RSC_OFS_FMT_SELECT, {31'h0, src});
      bus(1'b1, RSC_OFS_START_CTRL, 32'h1);
      repeat (4) @(negedge sys_clk_i);
      chk("run_before_sync", {31'h0, run}, 32'h0);
      @(posedge sys_clk_i);
      vs <= 1'b1;
      repeat (3) @(posedge sys_clk_i);
      mon <= 1'b1;
      dn = 0;
      repeat (30) @(posedge sys_clk_i);
      mon <= 1'b0; vs <= 1'b0; ae <= 1'b1;
      @(posedge sys_clk_i);
      ae <= 1'b0;
      repeat (2) @(negedge sys_clk_i);
      chk("run_after_end", {31'h0, run}, 32'h0);
      chk("area_done", dn, 32'h1);
      bus(1'b0, RSC_OFS_START_CTRL, 32'h0);
      chk("start_flag", q, {31'h0, !m[0]});
      bus(1'b1, RSC_OFS_START_CTRL, 32'h0);
    end
    src = 1'b0;
    qual = 1'b0;
    bus(1'b1, RSC_OFS_RUN_MODE, 32'h1);
    bus(1'b1, RSC_OFS_FMT_SELECT, 32'h2);
    bus(1'b1, RSC_OFS_START_CTRL, 32'h1);
    @(negedge sys_clk_i);
    chk("pass_thru", {31'h0, pt}, 32'h1);
    @(posedge sys_clk_i);
    vs <= 1'b1; dense <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    ls <= 1'b1;
    @(posedge sys_clk_i);
    cnt = 0;
    ls <= 1'b0;
    repeat (8300) @(posedge sys_clk_i);
    chk("raw_line_len", cnt, RSC_MAX_RAW_LINE);
    resetn_i <= 1'b0;
    @(negedge sys_clk_i);
    chk("run_in_reset", {31'h0, run}, 32'h0);
    chk("pass_thru_reset", {31'h0, pt}, 32'h0);
    chk("waitreq_reset", {31'h0, wq}, 32'h1);
    repeat (3) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    bus(1'b0, RSC_OFS_START_CTRL, 32'h0);
    chk("start_after_reset", q, 32'h0);
    end_of_test();
  end
endmodule : rsc_top_bench
